// ===== hw/rpo_pkg.sv
// Constants and types for the receive parallel output port.
// Notes on behaviour
// R1: Character and status outputs update just after each rising edge of the chosen clock.
// R2: Half-rate reference clock: outputs change on both reference clock edges.
// R3: Decoder enabled: character outputs carry decoded byte or special character.
// R4: Decoder bypassed: character outputs carry high eight bits of raw character.
// R5: Decoder bypassed: status bits one and zero carry raw low two bits.
// R6: Decoder bypassed: status bit two high when output character holds a comma.
// R7: Decoder enabled: all three status bits are coded receive status.
// R8: Parity control not low: odd-parity bit drives, timed like character outputs.
// R9: Parity control low: parity output driver is high impedance.
// R10: Ternary inputs decode low, middle, high; unconnected reads middle.
// R11: Recovered clock out at character rate, or half rate when rate select high.
// R12: Host captures half-rate data alternately on true and complement rising edges.
// R13: Status mode select picks one of two encodings, only with decoder enabled.
// R14: Eight character bits plus parity bit hold an odd number of ones.
package rpo_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int         AXI_AW       = 5;
    localparam logic [4:0] ADDR_CTRL    = 5'h00;
    localparam logic [4:0] ADDR_STATUS  = 5'h04;
    localparam logic [4:0] ADDR_INT_ST  = 5'h08;
    localparam logic [4:0] ADDR_INT_MSK = 5'h0C;
    localparam logic [4:0] ADDR_OUT_CHR = 5'h10;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam logic       CTRL_RST     = 1'h1;
    localparam logic       PARITY_RST   = 1'h1;
    localparam int         INT_BITS     = 3;
    localparam int         INT_UPDATE   = 0;
    localparam int         INT_OVERRUN  = 1;
    localparam int         INT_COMMA    = 2;
    // --------------------------------------------------------------
    // Pins and character coding
    // --------------------------------------------------------------
    localparam int         PIN_REF      = 0;
    localparam int         PIN_REC      = 1;
    localparam int         PIN_TXR      = 2;
    localparam int         PIN_RXR      = 3;
    localparam int         PIN_N        = 4;
    localparam logic [1:0] SENSE_FLOAT  = 2'h0;
    localparam logic [1:0] SENSE_LOW    = 2'h1;
    localparam logic [1:0] SENSE_HIGH   = 2'h2;
    localparam logic [6:0] COMMA_POS    = 7'h1F;
    localparam logic [6:0] COMMA_NEG    = 7'h60;
    localparam int         COMMA_TOP    = 9;
    localparam int         COMMA_BOT    = 3;
    localparam int         RAW_HI_BOT   = 2;
    localparam int         RAW_LO_TOP   = 1;
    typedef enum logic [1:0] {
        LVL_LOW  = 2'h0,
        LVL_MID  = 2'h1,
        LVL_HIGH = 2'h2
    } rpo_level_type;
    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } rpo_wr_state_type;
    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } rpo_rd_state_type;
    typedef struct packed {
        logic [9:0] raw;
        logic [7:0] dec_byte;
        logic [2:0] stat_a;
        logic [2:0] stat_b;
    } rpo_char_type;
    typedef struct packed {
        logic [2:0] status;
        logic [7:0] data;
    } rpo_out_type;
endpackage

// ===== hw/rpo_ternary.sv
// Synchroniser and decoder for one three-level static select pin.
`timescale 1ns/10ps
module rpo_ternary
    import rpo_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    // Pad comparator outputs: bit 1 above high threshold, bit 0 below low
    input  wire logic [1:0]    pin_sense,
    // Decoded level
    output rpo_level_type      level
);
    logic [1:0]    s1_r;
    logic [1:0]    s2_r;
    rpo_level_type lvl_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_r <= SENSE_FLOAT;
            s2_r <= SENSE_FLOAT;
        end else begin
            s1_r <= pin_sense;
            s2_r <= s1_r;
        end
    end

    // A floating pin self-biases between thresholds; a contradictory code is also middle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lvl_r <= LVL_MID;
        end else if (s2_r == SENSE_LOW) begin // R10
            lvl_r <= LVL_LOW;
        end else if (s2_r == SENSE_HIGH) begin
            lvl_r <= LVL_HIGH;
        end else begin
            lvl_r <= LVL_MID;
        end
    end

    assign level = lvl_r;

    a_float_is_mid: assert property ( // R10
        @(posedge core_clk) disable iff (sys_rst)
        ($past(pin_sense, 3) == SENSE_FLOAT) && !$past(sys_rst, 3) |-> (level == LVL_MID)
    ) else $error("floating select pin did not decode as middle");

endmodule // rpo_ternary

// ===== hw/rpo_port.sv
// Receive parallel output port with AXI4-Lite control and status.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module rpo_port
    import rpo_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // AXI4-Lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Received characters from the decoder stage
    input  rpo_char_type           char_in,
    input  wire logic              char_valid,
    // Clock and binary select pins
    input  wire logic              reference_clock,
    input  wire logic              recovered_char_clock,
    input  wire logic              tx_clock_rate_select,
    input  wire logic              rx_clock_rate_select,
    // Three-level select pins, pad comparator codes
    input  wire logic [1:0]        decoder_select,
    input  wire logic [1:0]        parity_control,
    input  wire logic [1:0]        rx_clock_source_select,
    input  wire logic [1:0]        rx_status_mode_select,
    // Parallel output pins
    output logic [7:0]             rx_char_out,
    output logic [2:0]             rx_status_out,
    output logic                   rx_odd_parity_out,
    output logic                   rx_odd_parity_oe,
    output logic                   rx_clk_out_p,
    output logic                   rx_clk_out_n,
    // Interrupt
    output logic                   irq
);
    // --------------------------------------------------------------
    // Pin synchronisers and edge detection
    // --------------------------------------------------------------
    logic [PIN_N-1:0] pin_s1_r;
    logic [PIN_N-1:0] pin_s2_r;
    logic             ref_d_r;
    logic             rec_d_r;
    logic             ref_rise;
    logic             ref_fall;
    logic             rec_rise;
    logic             txr;
    logic             rxr;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            ref_d_r  <= '0;
            rec_d_r  <= '0;
        end else begin
            pin_s1_r <= {rx_clock_rate_select, tx_clock_rate_select,
                         recovered_char_clock, reference_clock};
            pin_s2_r <= pin_s1_r;
            ref_d_r  <= pin_s2_r[PIN_REF];
            rec_d_r  <= pin_s2_r[PIN_REC];
        end
    end

    assign ref_rise = pin_s2_r[PIN_REF] & ~ref_d_r;
    assign ref_fall = ~pin_s2_r[PIN_REF] & ref_d_r;
    assign rec_rise = pin_s2_r[PIN_REC] & ~rec_d_r;
    assign txr      = pin_s2_r[PIN_TXR];
    assign rxr      = pin_s2_r[PIN_RXR];

    // --------------------------------------------------------------
    // Three-level selects
    // --------------------------------------------------------------
    rpo_level_type lvl_dec;
    rpo_level_type lvl_par;
    rpo_level_type lvl_cks;
    rpo_level_type lvl_mode;

    rpo_ternary u_dec (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_sense (decoder_select),
        .level     (lvl_dec)
    );
    rpo_ternary u_par (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_sense (parity_control),
        .level     (lvl_par)
    );
    rpo_ternary u_cks (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_sense (rx_clock_source_select),
        .level     (lvl_cks)
    );
    rpo_ternary u_mode (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_sense (rx_status_mode_select),
        .level     (lvl_mode)
    );

    logic dec_en;
    logic src_ref;
    assign dec_en  = (lvl_dec != LVL_LOW);
    assign src_ref = (lvl_cks == LVL_LOW);

    // --------------------------------------------------------------
    // Character holding and output register
    // --------------------------------------------------------------
    logic         ctrl_en_r;
    rpo_char_type held_r;
    logic         pending_r;
    rpo_out_type  out_r;
    rpo_out_type  out_nxt;
    logic         parity_r;
    logic         upd;
    logic         held_comma;

    // With the reference clock chosen the recovered clock rate select is ignored.
    always_comb begin
        if (src_ref) begin
            upd = ref_rise | (txr & ref_fall); // R2
        end else begin
            upd = rec_rise; // R1
        end
        upd = upd & ctrl_en_r;
    end

    assign held_comma = (held_r.raw[COMMA_TOP:COMMA_BOT] == COMMA_POS)
                      | (held_r.raw[COMMA_TOP:COMMA_BOT] == COMMA_NEG);

    always_comb begin
        if (dec_en) begin
            out_nxt.data = held_r.dec_byte; // R3
            if (lvl_mode == LVL_LOW) begin // R13
                out_nxt.status = held_r.stat_a; // R7
            end else begin
                out_nxt.status = held_r.stat_b;
            end
        end else begin
            out_nxt.data   = held_r.raw[COMMA_TOP:RAW_HI_BOT]; // R4
            out_nxt.status = {held_comma, held_r.raw[RAW_LO_TOP:0]}; // R5 R6
        end
    end

    // A character arriving in the cycle of an update keeps the pending flag set.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            held_r    <= '0;
            pending_r <= '0;
        end else if (char_valid) begin
            held_r    <= char_in;
            pending_r <= '1;
        end else if (upd) begin
            pending_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            out_r    <= '0;
            parity_r <= PARITY_RST;
        end else if (upd) begin
            out_r    <= out_nxt; // R1
            parity_r <= ~^out_nxt.data; // R8 R14
        end
    end

    assign rx_char_out       = out_r.data;
    assign rx_status_out     = out_r.status;
    assign rx_odd_parity_out = parity_r;
    assign rx_odd_parity_oe  = (lvl_par != LVL_LOW); // R8 R9

    // --------------------------------------------------------------
    // Receive clock output
    // --------------------------------------------------------------
    logic clk_p_r;
    logic clk_n_r;
    logic clk_nxt;

    // The output clock is rebuilt from samples, so it carries core-clock jitter.
    always_comb begin
        if (src_ref) begin
            clk_nxt = pin_s2_r[PIN_REF];
        end else if (rxr) begin
            clk_nxt = clk_p_r ^ rec_rise; // R11
        end else begin
            clk_nxt = pin_s2_r[PIN_REC]; // R11
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_p_r <= '0;
            clk_n_r <= '1;
        end else begin
            clk_p_r <= clk_nxt;
            clk_n_r <= ~clk_nxt;
        end
    end

    assign rx_clk_out_p = clk_p_r;
    assign rx_clk_out_n = clk_n_r;

    // --------------------------------------------------------------
    // Interrupt status
    // --------------------------------------------------------------
    logic [INT_BITS-1:0] int_stat_r;
    logic [INT_BITS-1:0] int_mask_r;
    logic [INT_BITS-1:0] int_ev;
    logic [INT_BITS-1:0] int_clr;

    always_comb begin
        int_ev              = '0;
        int_ev[INT_UPDATE]  = upd & pending_r;
        int_ev[INT_OVERRUN] = char_valid & pending_r & ~upd;
        int_ev[INT_COMMA]   = upd & pending_r & held_comma;
    end

    // An event in the cycle of its clear keeps the bit set.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_stat_r <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
        end
    end

    assign irq = |(int_stat_r & int_mask_r);

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    rpo_wr_state_type  wr_state_r;
    logic              aw_have_r;
    logic              w_have_r;
    logic [AXI_AW-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic              w_lane0_r;
    logic [1:0]        bresp_r;
    logic              wr_en;
    logic              wr_ok;

    assign s_axi_awready = (wr_state_r == WR_IDLE) & ~aw_have_r;
    assign s_axi_wready  = (wr_state_r == WR_IDLE) & ~w_have_r;
    assign wr_en         = (wr_state_r == WR_IDLE) & aw_have_r & w_have_r;
    assign wr_ok         = (aw_addr_r == ADDR_CTRL) | (aw_addr_r == ADDR_INT_ST)
                         | (aw_addr_r == ADDR_INT_MSK);
    assign int_clr       = (wr_en & w_lane0_r & (aw_addr_r == ADDR_INT_ST))
                         ? w_data_r[INT_BITS-1:0] : '0;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_have_r <= '0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= '1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_have_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            w_have_r  <= '0;
            w_data_r  <= '0;
            w_lane0_r <= '0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_have_r  <= '1;
            w_data_r  <= s_axi_wdata;
            w_lane0_r <= s_axi_wstrb[0];
        end else if (wr_en) begin
            w_have_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_state_r <= WR_IDLE;
            bresp_r    <= RESP_OKAY;
        end else begin
            case (wr_state_r)
                WR_IDLE: begin
                    if (wr_en) begin
                        wr_state_r <= WR_RESP;
                        bresp_r    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    assign s_axi_bvalid = (wr_state_r == WR_RESP);
    assign s_axi_bresp  = bresp_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_en_r  <= CTRL_RST;
            int_mask_r <= '0;
        end else if (wr_en & w_lane0_r) begin
            if (aw_addr_r == ADDR_CTRL) begin
                ctrl_en_r <= w_data_r[0];
            end else if (aw_addr_r == ADDR_INT_MSK) begin
                int_mask_r <= w_data_r[INT_BITS-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    rpo_rd_state_type rd_state_r;
    logic [31:0]      rdata_r;
    logic [1:0]       rresp_r;

    assign s_axi_arready = (rd_state_r == RD_IDLE);
    assign s_axi_rvalid  = (rd_state_r == RD_DATA);
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_state_r <= RD_IDLE;
            rdata_r    <= '0;
            rresp_r    <= RESP_OKAY;
        end else begin
            case (rd_state_r)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state_r <= RD_DATA;
                        rresp_r    <= RESP_OKAY;
                        if (s_axi_araddr == ADDR_CTRL) begin
                            rdata_r <= 32'(ctrl_en_r);
                        end else if (s_axi_araddr == ADDR_STATUS) begin
                            rdata_r <= 32'({rxr, txr, lvl_mode, lvl_cks, lvl_par, lvl_dec});
                        end else if (s_axi_araddr == ADDR_INT_ST) begin
                            rdata_r <= 32'(int_stat_r);
                        end else if (s_axi_araddr == ADDR_INT_MSK) begin
                            rdata_r <= 32'(int_mask_r);
                        end else if (s_axi_araddr == ADDR_OUT_CHR) begin
                            rdata_r <= 32'(out_r);
                        end else begin
                            rdata_r <= '0;
                            rresp_r <= RESP_SLVERR;
                        end
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state_r <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_r <= RD_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_hold_between_edges: assert property ( // R1
        @(posedge core_clk) disable iff (sys_rst)
        !$past(upd) |-> $stable(rx_char_out) && $stable(rx_status_out)
    ) else $error("outputs changed without a clock edge");

    a_half_rate_fall: assert property ( // R2
        @(posedge core_clk) disable iff (sys_rst)
        src_ref && txr && ref_fall && ctrl_en_r && pending_r && !char_valid
        |=> int_stat_r[INT_UPDATE] && !pending_r
    ) else $error("falling reference edge did not present a character");

    a_decoded_byte: assert property ( // R3
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && $past(dec_en) |-> rx_char_out == $past(held_r.dec_byte)
    ) else $error("decoded byte not presented");

    a_bypass_high_bits: assert property ( // R4
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && !$past(dec_en) |-> rx_char_out == $past(held_r.raw[9:2])
    ) else $error("raw high bits not presented");

    a_bypass_low_bits: assert property ( // R5
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && !$past(dec_en) |-> rx_status_out[1:0] == $past(held_r.raw[1:0])
    ) else $error("raw low bits not on status");

    a_bypass_comma: assert property ( // R6
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && !$past(dec_en) |-> rx_status_out[2] ==
        (($past(held_r.raw[9:3]) == COMMA_POS) || ($past(held_r.raw[9:3]) == COMMA_NEG))
    ) else $error("comma flag wrong");

    a_decoded_status: assert property ( // R7
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && $past(dec_en) && ($past(lvl_mode) != LVL_LOW)
        |-> rx_status_out == $past(held_r.stat_b)
    ) else $error("coded status not presented");

    a_mode_select: assert property ( // R13
        @(posedge core_clk) disable iff (sys_rst)
        $past(upd) && $past(dec_en) && ($past(lvl_mode) == LVL_LOW)
        |-> rx_status_out == $past(held_r.stat_a)
    ) else $error("status mode low not honoured");

    a_odd_parity: assert property ( // R8
        @(posedge core_clk) disable iff (sys_rst)
        rx_odd_parity_oe |-> ^{rx_char_out, rx_odd_parity_out} // R14
    ) else $error("parity is not odd");

    a_parity_off: assert property ( // R9
        @(posedge core_clk) disable iff (sys_rst)
        ($past(parity_control, 3) == SENSE_LOW) && !$past(sys_rst, 3) |-> !rx_odd_parity_oe
    ) else $error("parity driver on while disabled");

    a_half_char_clk: assert property ( // R11
        @(posedge core_clk) disable iff (sys_rst)
        $past(rec_rise) && !$past(src_ref) && $past(rxr) |-> rx_clk_out_p != $past(rx_clk_out_p)
    ) else $error("half-rate clock did not toggle");

endmodule // rpo_port

// ===== test/rpo_host.sv
// Host-side latch that captures the presented characters.
`timescale 1ns/10ps
module rpo_host (
    // Receive interface
    input  wire logic       clk_p,
    input  wire logic       clk_n,
    input  wire logic       half,
    input  wire logic [7:0] data,
    // Captured character
    output logic      [7:0] seen
);
    // At half rate each clock phase carries its own character.
    // One process keeps a single driver; a complement rise only counts at half rate.
    always @(posedge clk_p or posedge clk_n) if (clk_p || half) seen <= data;
endmodule // rpo_host

// ===== test/rpo_tb.sv
// Self-checking bench for the receive parallel output port.
`timescale 1ns/10ps
module testbench;
    import rpo_pkg::*;
    logic         core_clk = 0, sys_rst = 1, ref_clk = 0, rec_clk = 0, txr = 0, rxr = 0;
    logic [4:0]   awaddr = 0, araddr = 0;
    logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cval = 0;
    logic [31:0]  wdata = 0, rdata, rd;
    logic [3:0]   wstrb = 4'hF;
    logic [1:0]   bresp, rresp, rs, dsel = 0, pctl = 0, csel = 2'h1, mode = 0;
    logic         awready, wready, bvalid, arready, rvalid, poe, ck_p, ck_n, irq, par;
    logic [7:0]   dout, seen;
    logic [2:0]   sout;
    rpo_char_type cin = '0;
    int           mismatches = 0, n_compared = 0;
    always #10 core_clk = ~core_clk;
    // The reference clock runs free at one eighth of the core clock rate, its edges falling on core clock falling edges.
    always #80 ref_clk = ~ref_clk;
    always #80 rec_clk = ~rec_clk;
    rpo_port dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .char_in(cin), .char_valid(cval),
        .reference_clock(ref_clk), .recovered_char_clock(rec_clk),
        .tx_clock_rate_select(txr), .rx_clock_rate_select(rxr), .decoder_select(dsel),
        .parity_control(pctl), .rx_clock_source_select(csel),
        .rx_status_mode_select(mode), .rx_char_out(dout), .rx_status_out(sout),
        .rx_odd_parity_out(par), .rx_odd_parity_oe(poe), .rx_clk_out_p(ck_p),
        .rx_clk_out_n(ck_n), .irq(irq));
    rpo_host host (.clk_p(ck_p), .clk_n(ck_n), .half(rxr), .data(dout), .seen(seen));
    task automatic end_sim();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic await(input int k);
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge core_clk);
            if (k == 0 && bvalid || k == 1 && arready || k == 2 && rvalid
                || k == 3 && !ck_p || k == 4 && ck_p) break;
        end
        if (i == 60) begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int  i;
        bit  ta, tw;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1;
        wvalid  <= 1;
        for (i = 0; i < 60; i++) begin
            @(negedge core_clk);
            if (!awvalid && !wvalid) break;
            ta = awready;
            tw = wready;
            @(posedge core_clk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
        if (i == 60) begin
            mismatches++;
            end_sim();
        end
        @(posedge core_clk);
        bready <= 1;
        await(0);
        @(posedge core_clk);
        bready <= 0;
        @(negedge core_clk);
    endtask
    task automatic rd_reg(input logic [4:0] a);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1;
        await(1);
        @(posedge core_clk);
        arvalid <= 0;
        rready  <= 1;
        await(2);
        rd = rdata;
        rs = rresp;
        @(posedge core_clk);
        rready <= 0;
    endtask
    // Three clock rises guarantee the new character has been presented.
    task automatic pres(input rpo_char_type c);
        @(posedge core_clk);
        cin  <= c;
        cval <= 1;
        @(posedge core_clk);
        cval <= 0;
        repeat (3) begin
            await(3);
            await(4);
        end
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic t_bypass();
        @(posedge core_clk);
        dsel <= 2'h1;
        pres('{raw: 10'h0FD, default: '0});
        chk("char", 8'h3F, dout);
        chk("stat", 3'h5, sout);
        chk("par", 1'h1, par);
        chk("oe", 1'h1, poe);
        pres('{raw: 10'h2A5, default: '0});
        chk("char", 8'hA9, dout);
        chk("stat", 3'h1, sout);
    endtask
    task automatic t_enabled();
        @(posedge core_clk);
        dsel <= 2'h2;
        mode <= 2'h1;
        pres('{raw: 10'h0FD, dec_byte: 8'h5A, stat_a: 3'h3, stat_b: 3'h6});
        chk("char", 8'h5A, dout);
        chk("stat", 3'h3, sout);
        chk("par", 1'h1, par);
        @(posedge core_clk);
        mode <= 2'h2;
        txr  <= 1;
        pres('{raw: 10'h0FD, dec_byte: 8'h5B, stat_a: 3'h3, stat_b: 3'h6});
        chk("stat", 3'h6, sout);
        chk("par", 1'h0, par);
    endtask
    task automatic t_recovered();
        @(posedge core_clk);
        csel <= 2'h0;
        rxr  <= 1;
        txr  <= 0;
        pres('{raw: 10'h0FD, dec_byte: 8'hC3, default: '0});
        chk("char", 8'hC3, dout);
        chk("host", 8'hC3, seen);
        @(posedge core_clk);
        csel <= 2'h1;
        rxr  <= 0;
    endtask
    task automatic t_regs();
        @(posedge core_clk);
        pctl <= 2'h1;
        dsel <= 2'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk("oe", 1'h0, poe);
        rd_reg(ADDR_STATUS);
        chk("status", 32'h81, rd);
        rd_reg(5'h14);
        chk("resp", RESP_SLVERR, rs);
    endtask
    task automatic t_irq();
        wr(ADDR_INT_ST, 32'h7);
        wr(ADDR_INT_MSK, 32'h1);
        chk("irq", 1'h0, irq);
        pres('{raw: 10'h155, default: '0});
        chk("irq", 1'h1, irq);
        wr(ADDR_INT_MSK, 32'h0);
        chk("irq", 1'h0, irq);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_INT_ST, 32'h7);
        wr(ADDR_INT_MSK, 32'h1);
        chk("irq", 1'h0, irq);
        rd_reg(ADDR_INT_ST);
        chk("int", 32'h0, rd);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 0;
        t_bypass();
        t_enabled();
        t_recovered();
        t_regs();
        t_irq();
        end_sim();
    end
endmodule // testbench
